// ==== sys_reset_ctrl.v ====
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "sys_reset_ctrl_regs.vh"
module sys_reset_ctrl #(
	parameter RST_FILT = `RST_PULSE_CYC
) (
	input wire clk_sys,
	input wire reset,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire reset_pin_n,
	input wire reset_function_pin,
	input wire deep_sleep_wake_pin,
	input wire rtc_wake,
	input wire wdt_reset,
	input wire por,
	input wire droop_below_irq_lo,
	input wire droop_below_irq_hi,
	input wire droop_below_rst_lo,
	input wire droop_below_rst_hi,
	input wire [31:0] prot_word,
	input wire prot_word_valid,
	input wire test_reset,
	output reg chip_reset,
	output reg internal_rc_osc_start,
	output reg flash_ctrl_init,
	output reg [31:0] fetch_addr,
	output reg deep_pd,
	output reg droop_irq,
	output reg swd_enable,
	output reg scan_enable,
	output reg isp_enable,
	output reg isp_pin_entry_enable,
	output reg isp_partial_ok,
	output reg isp_sector0_ok,
	output reg isp_full_erase_ok,
	output reg app_flash_calls_enable
);
// ----------------------------------------
// state
// ----------------------------------------
reg [7:0] ctrl;
reg [3:0] cause;
reg [1:0] level;
reg [7:0] pin_cnt;
reg pin_rst;
reg scan_mode;
reg [1:0] rst_sync;
wire pin_ok;
wire droop_irq_now;
wire droop_rst_now;
wire any_src;
wire [3:0] src_vec;
assign pin_ok = reset_function_pin & ~deep_pd;
function pick_level;
	input sel;
	input lo;
	input hi;
	begin
		pick_level = sel ? hi : lo;
	end
endfunction
assign droop_irq_now = pick_level(ctrl[`CTRL_IRQ_SEL],
	droop_below_irq_lo, droop_below_irq_hi);
assign droop_rst_now = ctrl[`CTRL_RST_EN] &
	pick_level(ctrl[`CTRL_RST_SEL],
	droop_below_rst_lo, droop_below_rst_hi);
assign src_vec = {droop_rst_now, por, wdt_reset, pin_rst};
assign any_src = |src_vec;
// ----------------------------------------
// reset pin filter
// ----------------------------------------
always @(posedge clk_sys) begin
	if (reset | ~pin_ok | reset_pin_n) begin
		pin_cnt <= 8'h00;
		pin_rst <= 1'b0;
	end else if (pin_cnt < RST_FILT[7:0] - 8'h01) begin
		pin_cnt <= pin_cnt + 8'h01;
	end else begin
		pin_rst <= 1'b1;
	end
end
// ----------------------------------------
// reset merge
// ----------------------------------------
always @(posedge clk_sys) begin
	if (reset | any_src) begin
		rst_sync <= 2'b11;
	end else begin
		rst_sync <= {rst_sync[0], 1'b0};
	end
end
always @(posedge clk_sys) begin
	if (reset) begin
		chip_reset <= 1'b1;
	end else begin
		chip_reset <= rst_sync[1] | any_src;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		internal_rc_osc_start <= 1'b1;
	end else begin
		internal_rc_osc_start <= any_src | rst_sync[1] |
			internal_rc_osc_start;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		flash_ctrl_init <= 1'b1;
	end else begin
		flash_ctrl_init <= any_src | rst_sync[1];
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		fetch_addr <= `BOOT_VECTOR;
	end else if (chip_reset) begin
		fetch_addr <= `BOOT_VECTOR;
	end
end
// ----------------------------------------
// deep power-down
// ----------------------------------------
always @(posedge clk_sys) begin
	if (reset | chip_reset) begin
		deep_pd <= 1'b0;
	end else if (deep_pd) begin
		if (~deep_sleep_wake_pin | rtc_wake) begin
			deep_pd <= 1'b0;
		end
	end else if (wr && addr == `ADDR_CTRL && wdata[`CTRL_DPD_REQ] &&
		!ctrl[`CTRL_DPD_LOCK]) begin
		deep_pd <= 1'b1;
	end
end
// ----------------------------------------
// registers
// ----------------------------------------
always @(posedge clk_sys) begin
	if (reset) begin
		ctrl <= `CTRL_RESET;
	end else if (wr && addr == `ADDR_CTRL) begin
		ctrl <= {wdata[7:1], 1'b0};
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		cause <= 4'h0;
	end else if (wr && addr == `ADDR_CAUSE) begin
		cause <= (cause & ~wdata[3:0]) | src_vec;
	end else begin
		cause <= cause | src_vec;
	end
end
always @(posedge clk_sys) begin
	if (reset) begin
		rdata <= 32'h00000000;
	end else if (rd) begin
		case (addr)
		`ADDR_CTRL: rdata <= {24'h000000, ctrl};
		`ADDR_STATUS: rdata <= {28'h0000000, deep_pd, scan_mode,
			droop_rst_now, droop_irq_now};
		`ADDR_CAUSE: rdata <= {28'h0000000, cause};
		`ADDR_PROT: rdata <= {30'h00000000, level};
		default: rdata <= 32'h00000000;
		endcase
	end else begin
		rdata <= 32'h00000000;
	end
end
// ----------------------------------------
// protection level
// ----------------------------------------
function [1:0] prot_decode;
	input [31:0] w;
	begin
		case (w)
		`PROT_PAT_L1: prot_decode = `PROT_L1;
		`PROT_PAT_L2: prot_decode = `PROT_L2;
		`PROT_PAT_L3: prot_decode = `PROT_L3;
		default: prot_decode = `PROT_NONE;
		endcase
	end
endfunction

always @(posedge clk_sys) begin
	if (reset) begin
		level <= `PROT_NONE;
	end else if (chip_reset && prot_word_valid) begin
		level <= prot_decode(prot_word);
	end
end
// ----------------------------------------
// test port scan mode
// ----------------------------------------
always @(posedge clk_sys) begin
	if (reset) begin
		scan_mode <= 1'b0;
	end else if (test_reset) begin
		scan_mode <= 1'b0;
	end else if (!reset_pin_n) begin
		scan_mode <= 1'b1;
	end
end
// ----------------------------------------
// level decode
// ----------------------------------------
function lvl_open;
	input [1:0] lv;
	begin
		lvl_open = (lv == `PROT_NONE);
	end
endfunction

function lvl_sealed;
	input [1:0] lv;
	begin
		lvl_sealed = (lv == `PROT_L3);
	end
endfunction

function lvl_partial;
	input [1:0] lv;
	begin
		lvl_partial = (lv == `PROT_NONE) || (lv == `PROT_L1);
	end
endfunction

// ----------------------------------------
// next values
// ----------------------------------------
reg next_droop_irq;
reg next_swd_enable;
reg next_scan_enable;
reg next_isp_enable;
reg next_isp_pin_entry;
reg next_isp_partial;
reg next_isp_sector0;
reg next_isp_full_erase;
reg next_app_calls;

always @* begin
	next_droop_irq = droop_irq_now;
	next_swd_enable = 1'b1;
	if (chip_reset) begin
		next_swd_enable = 1'b0;
	end
	if (!reset_pin_n) begin
		next_swd_enable = 1'b0;
	end
	if (scan_mode) begin
		next_swd_enable = 1'b0;
	end
	if (!lvl_open(level)) begin
		next_swd_enable = 1'b0;
	end
	next_scan_enable = scan_mode;
	next_isp_enable = !lvl_sealed(level);
	next_isp_pin_entry = !lvl_sealed(level);
	next_isp_partial = lvl_partial(level);
	next_isp_sector0 = lvl_open(level);
	next_isp_full_erase = !lvl_sealed(level);
	next_app_calls = 1'b1;
end

// ----------------------------------------
// output registers
// ----------------------------------------
always @(posedge clk_sys) begin
	if (reset) begin
		droop_irq <= 1'b0;
	end else begin
		droop_irq <= next_droop_irq;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		swd_enable <= 1'b0;
	end else begin
		swd_enable <= next_swd_enable;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		scan_enable <= 1'b0;
	end else begin
		scan_enable <= next_scan_enable;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		isp_enable <= 1'b0;
	end else begin
		isp_enable <= next_isp_enable;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		isp_pin_entry_enable <= 1'b0;
	end else begin
		isp_pin_entry_enable <= next_isp_pin_entry;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		isp_partial_ok <= 1'b0;
	end else begin
		isp_partial_ok <= next_isp_partial;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		isp_sector0_ok <= 1'b0;
	end else begin
		isp_sector0_ok <= next_isp_sector0;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		isp_full_erase_ok <= 1'b0;
	end else begin
		isp_full_erase_ok <= next_isp_full_erase;
	end
end

always @(posedge clk_sys) begin
	if (reset) begin
		app_flash_calls_enable <= 1'b0;
	end else begin
		app_flash_calls_enable <= next_app_calls;
	end
end
endmodule

// ==== sys_reset_ctrl_regs.vh ====
`ifndef SYS_RESET_CTRL_REGS_VH
`define SYS_RESET_CTRL_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CAUSE 8'h08
`define ADDR_PROT 8'h0c
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_DPD_REQ 0
`define CTRL_DPD_LOCK 1
`define CTRL_IRQ_SEL 2
`define CTRL_RST_SEL 3
`define CTRL_RST_EN 4
`define CTRL_RESET 8'h00
// ----------------------------------------
// cause bits
// ----------------------------------------
`define CAUSE_PIN 0
`define CAUSE_WDT 1
`define CAUSE_POR 2
`define CAUSE_DROOP 3
// ----------------------------------------
// protection patterns and levels
// ----------------------------------------
`define PROT_PAT_L1 32'h12345678
`define PROT_PAT_L2 32'h87654321
`define PROT_PAT_L3 32'h43218765
`define PROT_NONE 2'h0
`define PROT_L1 2'h1
`define PROT_L2 2'h2
`define PROT_L3 2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_PS 8000
`define RST_PULSE_MIN_PS 50000
`define RST_PULSE_CYC ((`RST_PULSE_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BOOT_VECTOR 32'h00000000
`endif

// ==== sys_reset_ctrl_asserts.sv ====
`timescale 1ns/1ps
module sys_reset_ctrl_asserts #(
	parameter RST_FILT = 7
) (
	input wire clk_sys,
	input wire reset,
	input wire reset_pin_n,
	input wire reset_function_pin,
	input wire deep_sleep_wake_pin,
	input wire rtc_wake,
	input wire wdt_reset,
	input wire por,
	input wire chip_reset,
	input wire internal_rc_osc_start,
	input wire [31:0] fetch_addr,
	input wire deep_pd,
	input wire swd_enable,
	input wire scan_enable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_fetch_zero: assert property (fetch_addr == 32'h0)
		else $error("fetch not zero");
	a_osc_in_reset: assert property (chip_reset |-> internal_rc_osc_start)
		else $error("osc off in reset");
	a_swd_in_reset: assert property (chip_reset && $past(chip_reset)
		|-> !swd_enable) else $error("debug open in reset");
	a_scan_no_swd: assert property (scan_enable && $past(scan_enable)
		|-> !swd_enable) else $error("debug open in scan");
	a_pin_selects: assert property (!reset_pin_n && $past(!reset_pin_n)
		|-> !swd_enable) else $error("debug open, pin low");
	a_pin_resets: assert property (
		(!reset_pin_n && reset_function_pin && !deep_pd) [*7]
		|-> ##[0:2] chip_reset) else $error("pin reset missed");
	a_dpd_holds: assert property (
		deep_pd && deep_sleep_wake_pin && !rtc_wake && !wdt_reset && !por
		&& !chip_reset |=> deep_pd) else $error("left deep power-down");
	a_wake_exit: assert property (
		deep_pd && (!deep_sleep_wake_pin || rtc_wake) |=> !deep_pd)
		else $error("wake ignored");
endmodule
bind sys_reset_ctrl sys_reset_ctrl_asserts #(.RST_FILT(RST_FILT)) chk_i (.*);

// ==== sys_reset_far_pins.sv ====
`timescale 1ns/1ps
module sys_reset_far_pins (
	input wire clk_sys,
	input wire deep_pd,
	input wire [3:0] rst_len,
	input wire wake_req,
	output reg reset_pin_n = 1'b1,
	output reg deep_sleep_wake_pin = 1'b1
);
	reg [3:0] cnt = 4'h0;
	always @(posedge clk_sys) begin
		if (rst_len != 4'h0 && cnt == 4'h0 && !deep_pd) begin
			cnt <= rst_len;
			reset_pin_n <= 1'b0;
		end else if (cnt > 4'h1) begin
			cnt <= cnt - 4'h1;
		end else begin
			cnt <= 4'h0;
			reset_pin_n <= 1'b1;
		end
		deep_sleep_wake_pin <= !(wake_req && deep_pd);
	end
endmodule

// ==== system_reset_wake_protect_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`include "sys_reset_ctrl_regs.vh"
module system_reset_wake_protect_ctrl_tb_top;
	reg clk_sys = 0, reset = 1, wr = 0, rd = 0, rtc_wake = 0, por = 0;
	reg wdt_reset = 0, lo = 0, hi = 0, pv = 0, test_reset = 0, wake_req = 0;
	reg [3:0] rst_len = 0;
	reg [7:0] addr = 0;
	reg [31:0] wdata = 0, pw = 0, seed = 32'h9628;
	wire [31:0] rdata, fetch_addr;
	wire reset_pin_n, deep_sleep_wake_pin, chip_reset, deep_pd, droop_irq;
	wire swd_enable, scan_enable, isp_enable, isp_partial_ok, app_ok;
	integer bad_count = 0, checked = 0, i;
	sys_reset_ctrl uut (.clk_sys, .reset, .addr, .wdata, .wr, .rd, .rdata,
		.reset_pin_n, .reset_function_pin(1'b1), .deep_sleep_wake_pin,
		.rtc_wake, .wdt_reset, .por, .droop_below_irq_lo(lo),
		.droop_below_irq_hi(hi), .droop_below_rst_lo(1'b0),
		.droop_below_rst_hi(1'b0), .prot_word(pw), .prot_word_valid(pv),
		.test_reset, .chip_reset, .internal_rc_osc_start(),
		.flash_ctrl_init(), .fetch_addr, .deep_pd, .droop_irq, .swd_enable,
		.scan_enable, .isp_enable, .isp_pin_entry_enable(), .isp_partial_ok,
		.isp_sector0_ok(), .isp_full_erase_ok(),
		.app_flash_calls_enable(app_ok));
	sys_reset_far_pins far (.clk_sys, .deep_pd, .rst_len, .wake_req,
		.reset_pin_n, .deep_sleep_wake_pin);
	initial forever #4 clk_sys = ~clk_sys;
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [63:0] n, input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0s exp %h got %h", n, exp, got);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk_sys);
	endtask
	task wreg(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk_sys);
			addr <= a;
			wdata <= d;
			wr <= 1;
			@(posedge clk_sys);
			wr <= 0;
		end
	endtask
	task rreg(input [7:0] a, input [31:0] e);
		begin
			@(posedge clk_sys);
			addr <= a;
			rd <= 1;
			@(posedge clk_sys);
			rd <= 0;
			#1 chk("rdata", rdata, e);
		end
	endtask
	task settle;
		begin
			repeat (40) if (chip_reset !== 1'b0) @(posedge clk_sys);
			#1 chk("rst", chip_reset, 0);
		end
	endtask
	task wrap_up;
		begin
			$display("checked %0d bad_count %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		#100000;
		bad_count = bad_count + 1;
		wrap_up;
	end
	initial begin
		cyc(3);
		reset <= 0;
		settle;
		chk("fetch", fetch_addr, 0);
		rreg(`ADDR_CTRL, `CTRL_RESET);
		rst_len <= 6;
		cyc(1);
		rst_len <= 0;
		cyc(10);
		chk("short", chip_reset, 0);
		for (i = 0; i < 3; i = i + 1) begin
			wreg(`ADDR_CAUSE, 32'hf);
			rst_len <= (i == 0) ? 4'h7 : 4'h0;
			{por, wdt_reset} <= i[1:0];
			cyc(1);
			rst_len <= 0;
			cyc(2);
			{por, wdt_reset} <= 2'b00;
			cyc(8);
			settle;
			rreg(`ADDR_CAUSE, 1 << i);
		end
		chk("scan", scan_enable, 1);
		chk("swd", swd_enable, 0);
		test_reset <= 1;
		cyc(2);
		test_reset <= 0;
		cyc(3);
		chk("swd", swd_enable, 1);
		pv <= 1;
		for (i = 3; i >= 0; i = i - 1) begin
			pw <= (i == 3) ? `PROT_PAT_L3 : (i == 2) ? `PROT_PAT_L2 :
				(i == 1) ? `PROT_PAT_L1 : 32'h0;
			wdt_reset <= 1;
			cyc(3);
			wdt_reset <= 0;
			cyc(2);
			settle;
			rreg(`ADDR_PROT, i);
			chk("swd", swd_enable, i == 0);
			chk("isp", isp_enable, i != 3);
			chk("part", isp_partial_ok, i < 2);
			chk("iap", app_ok, 1);
		end
		for (i = 0; i < 8; i = i + 1) begin
			seed = lfsr(seed);
			wreg(`ADDR_CTRL, {29'h0, seed[2], 2'b00});
			lo <= seed[0];
			hi <= seed[1];
			cyc(3);
			chk("irq", droop_irq, seed[2] ? seed[1] : seed[0]);
			rreg(`ADDR_STATUS, seed[2] ? seed[1] : seed[0]);
		end
		wreg(`ADDR_CTRL, 32'h2);
		wreg(`ADDR_CTRL, 32'h3);
		cyc(3);
		chk("lock", deep_pd, 0);
		wreg(`ADDR_CTRL, 32'h0);
		for (i = 0; i < 2; i = i + 1) begin
			wreg(`ADDR_CTRL, 32'h1);
			cyc(5);
			chk("dpd", deep_pd, 1);
			rtc_wake <= i[0];
			wake_req <= !i[0];
			cyc(3);
			chk("wake", deep_pd, 0);
			rtc_wake <= 0;
			wake_req <= 0;
		end
		wrap_up;
	end
endmodule
